// >>> bench/ahp_cfg_properties.sv
// Port-level assertions for the packetizer configuration block.
`timescale 1ns/1ps
module ahp_cfg_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic soft_reset,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic cyc_ser_active,
    input wire logic [31:0] pkt_data,
    input wire logic pkt_last,
    input wire logic pkt_valid,
    input wire logic pkt_ready
);
    // ------------------------------------------------------------
    // Serial word length counter
    // ------------------------------------------------------------
    logic [5:0] ser_cnt_ff;
    logic [5:0] nxt_ser_cnt;
    always_comb begin
        nxt_ser_cnt = cyc_ser_active ? ser_cnt_ff + 6'h01 : 6'h00;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ser_cnt_ff <= 6'h00;
        end else begin
            ser_cnt_ff <= nxt_ser_cnt;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    stall_hold_a: assert property (
        pkt_valid && !pkt_ready && !soft_reset |=> pkt_valid && $stable({pkt_data, pkt_last}))
        else $error("stream word changed in stall");
    ser_len_a: assert property ($fell(cyc_ser_active) |-> ser_cnt_ff == 6'h20)
        else $error("serial word not 32 cycles");
    ser_max_a: assert property (ser_cnt_ff <= 6'h20)
        else $error("serial word too long");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    r_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    rd_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered");
    b_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write taken early");
    soft_clear_a: assert property (soft_reset |=> !pkt_valid)
        else $error("stream not cleared");
endmodule // ahp_cfg_properties
bind ahp_packetizer_cfg ahp_cfg_properties chk (.aclk, .aresetn, .soft_reset, .s_axi_awready,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .cyc_ser_active, .pkt_data, .pkt_last, .pkt_valid, .pkt_ready);

// >>> bench/ahp_sink_model.sv
// Packet sink model that takes the test stream promptly or with long stalls.
`timescale 1ns/1ps
module ahp_sink_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow,
    output logic pkt_ready
);
    logic [1:0] ph_ff;
    logic [1:0] nxt_ph;
    always_comb begin
        nxt_ph = ph_ff + 2'h1;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ph_ff <= 2'h0;
        end else begin
            ph_ff <= nxt_ph;
        end
    end
    // Slow mode takes one word in four, so the buffer fills and must hold its words.
    assign pkt_ready = !slow || (ph_ff == 2'h3);
endmodule // ahp_sink_model

// >>> bench/auto_tx_header_packetizer_cfg_test.sv
// Register and test stream testbench for the packetizer configuration block.
`timescale 1ns/1ps
module auto_tx_header_packetizer_cfg_test
    import ahp_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn, soft_reset, awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
    logic arready, rvalid, rready, cyc_start, ser_out, ser_act, plast, pvalid, pready, slow;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, ctimer, pdata, rd, cnt;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    int mismatches = 0;
    int num_checks = 0;
    logic [11:0] ofs [5] = '{OFS_ASYNC_HDR_1, OFS_ASYNC_HDR_2, OFS_ASYNC_HDR_3, OFS_ISO_TX_HDR,
        OFS_PKT_CTRL};
    logic [31:0] msk [5] = '{MASK_FULL, MASK_FULL, MASK_FULL, MASK_ISO_TX_HDR, MASK_PKT_CTRL};
    always #10 aclk = ~aclk;
    ahp_sink_model sink (.aclk, .aresetn, .slow, .pkt_ready(pready));
    ahp_packetizer_cfg uut (.aclk, .aresetn, .soft_reset, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .iso_cycle_start(cyc_start), .cycle_timer(ctimer), .cyc_ser_out(ser_out),
        .cyc_ser_active(ser_act), .pkt_data(pdata), .pkt_last(plast), .pkt_valid(pvalid),
        .pkt_ready(pready));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected response at %0t: %b not %b", $time, got, exp);
        end
    endtask
    task automatic hang(input int n);
        if (n >= 60) begin
            mismatches++;
            $display("unexpected timeout at %0t", $time);
            finish_test();
        end
    endtask
    // The response ready is raised late so that the slave must hold its answer.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) break;
            if (n >= 2) bready <= 1'b1;
        end
        bready <= 1'b0;
        hang(n);
    endtask
    task automatic rd_reg(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic ta, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) break;
            if (n >= 2) rready <= 1'b1;
        end
        rready <= 1'b0;
        hang(n);
    endtask
    task automatic rst_vals();
        logic [31:0] ev [5] = '{32'h3FC1_0000, 32'h0, 32'h0008_0000, 32'h0010_0010, 32'h8000_0000};
        for (int i = 0; i < 5; i++) begin
            rd_reg(ofs[i], rd, rs);
            chk(rd, ev[i]);
            chk_resp(rs, RESP_OKAY);
        end
    endtask
    task automatic take(input logic [31:0] d, input logic l);
        int n;
        for (n = 0; n < 60; n++) begin
            @(negedge aclk);
            if (pvalid && pready) break;
        end
        hang(n);
        chk(pdata, d);
        chk({31'h0, plast}, {31'h0, l});
        @(posedge aclk);
    endtask
    task automatic pkt(input logic [31:0] hdr, input int nq);
        take(hdr, nq == 0);
        for (int i = 0; i < nq; i++) begin
            take(cnt, i == nq - 1);
            cnt++;
        end
    endtask
    task automatic pulse();
        @(posedge aclk);
        cyc_start <= 1'b1;
        @(posedge aclk);
        cyc_start <= 1'b0;
    endtask
    task automatic idle_chk();
        repeat (20) @(negedge aclk);
        chk({31'h0, pvalid}, 32'h0);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {aresetn, soft_reset, awvalid, wvalid, bready, arvalid, rready, cyc_start, slow} = '0;
        {awaddr, araddr, wdata, wstrb, ctimer} = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rst_vals();
        for (int i = 0; i < 5; i++) begin
            wr(ofs[i], 32'hFFFF_FFFF, rs);
            chk_resp(rs, RESP_OKAY);
            rd_reg(ofs[i], rd, rs);
            chk(rd, msk[i]);
            wr(ofs[i], 32'h0, rs);
            rd_reg(ofs[i], rd, rs);
            chk(rd, 32'h0);
        end
        wr(12'h1B0, 32'h1234_5678, rs);
        chk_resp(rs, RESP_SLVERR);
        rd_reg(12'h1B0, rd, rs);
        chk_resp(rs, RESP_SLVERR);
        wr(OFS_ISO_TX_HDR, 32'h0008_9A05, rs);
        wr(OFS_PKT_CTRL, 32'h1000_0000, rs);
        slow <= 1'b1;
        cnt = 32'h0;
        pulse();
        pkt(32'h0008_9A05, 2);
        pulse();
        pkt(32'h0008_9A05, 2);
        idle_chk();
        wr(OFS_PKT_CTRL, 32'h3000_0000, rs);
        pulse();
        pkt({TS_PKT_BYTES, 16'h9A05}, int'(TS_PKT_BYTES) / 4);
        idle_chk();
        wr(OFS_PKT_CTRL, 32'h0, rs);
        pulse();
        idle_chk();
        wr(OFS_PKT_CTRL, 32'h8000_0000, rs);
        ctimer <= 32'hA5C3_0F96;
        pulse();
        for (int n = 0; n <= 60; n++) begin
            @(negedge aclk);
            if (ser_act === 1'b1) break;
            hang(n);
        end
        for (int i = 0; i < 32; i++) begin
            rd = {rd[30:0], ser_out};
            @(negedge aclk);
        end
        chk(rd, 32'hA5C3_0F96);
        chk({31'h0, ser_act}, 32'h0);
        wr(OFS_PKT_CTRL, 32'h2000_0000, rs);
        pulse();
        repeat (8) @(posedge aclk);
        soft_reset <= 1'b1;
        @(posedge aclk);
        soft_reset <= 1'b0;
        rst_vals();
        wr(OFS_PKT_CTRL, 32'h1000_0000, rs);
        cnt = 32'h0;
        pulse();
        pkt(32'h0010_0010, 4);
        finish_test();
    end
endmodule // auto_tx_header_packetizer_cfg_test

// >>> logic/ahp_packetizer_cfg.sv
// Header registers, test packet generator and serial cycle-timer shifter with an AXI4-Lite slave.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module ahp_packetizer_cfg
    import ahp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic soft_reset,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic iso_cycle_start,
    input wire logic [31:0] cycle_timer,
    output logic cyc_ser_out,
    output logic cyc_ser_active,
    output logic [31:0] pkt_data,
    output logic pkt_last,
    output logic pkt_valid,
    input wire logic pkt_ready
);

    // -----------------------------------------------------------------
    // Reset
    // -----------------------------------------------------------------
    logic srst_n;
    assign srst_n = aresetn && !soft_reset;

    // -----------------------------------------------------------------
    // AXI4-Lite handshake state
    // -----------------------------------------------------------------
    logic awready_ff, nxt_awready;
    logic wready_ff, nxt_wready;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic [ADDR_W-1:0] waddr_ff, nxt_waddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic arready_ff, nxt_arready;
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;
    logic wr_fire;
    logic wr_hit;
    logic [31:0] rd_value;
    logic rd_hit;

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    logic [31:0] ahdr1_ff, nxt_ahdr1;
    logic [31:0] ahdr2_ff, nxt_ahdr2;
    logic [31:0] ahdr3_ff, nxt_ahdr3;
    logic [31:0] iso_hdr_ff, nxt_iso_hdr;
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [31:0] alt_ff, nxt_alt;
    logic [5:0] shift_cnt_ff, nxt_shift_cnt;
    logic ser_out_ff, nxt_ser_out;
    logic ser_act_ff, nxt_ser_act;

    logic ser_en;
    logic ts_test_en;
    logic iso_test_en;
    assign ser_en = ctrl_ff[CTL_SER_BIT];
    assign ts_test_en = ctrl_ff[CTL_TS_TEST_BIT];
    assign iso_test_en = ctrl_ff[CTL_ISO_TEST_BIT];

    // -----------------------------------------------------------------
    // Bus handshake
    // -----------------------------------------------------------------
    assign wr_fire = !awready_ff && !wready_ff && !bvalid_ff;

    always_comb begin
        nxt_awready = awready_ff;
        nxt_wready = wready_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_waddr = waddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        if (awready_ff && s_axi_awvalid) begin
            nxt_awready = 1'b0;
            nxt_waddr = s_axi_awaddr;
        end
        if (wready_ff && s_axi_wvalid) begin
            nxt_wready = 1'b0;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (wr_fire) begin
            nxt_bvalid = 1'b1;
            nxt_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
            nxt_awready = 1'b1;
            nxt_wready = 1'b1;
        end
    end

    always_comb begin
        nxt_arready = arready_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (arready_ff && s_axi_arvalid) begin
            nxt_arready = 1'b0;
            nxt_rvalid = 1'b1;
            nxt_rdata = rd_value;
            nxt_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
            nxt_arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            waddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else begin
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            waddr_ff <= nxt_waddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    // -----------------------------------------------------------------
    // Read decode
    // -----------------------------------------------------------------
    always_comb begin
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            OFS_ASYNC_HDR_1: rd_value = ahdr1_ff;
            OFS_ASYNC_HDR_2: rd_value = ahdr2_ff;
            OFS_ASYNC_HDR_3: rd_value = ahdr3_ff;
            OFS_ISO_TX_HDR: rd_value = iso_hdr_ff & MASK_ISO_TX_HDR;
            OFS_PKT_CTRL: rd_value = ctrl_ff & MASK_PKT_CTRL;
            OFS_ALT_CTRL: rd_value = alt_ff;
            default: begin
                rd_value = '0;
                rd_hit = 1'b0;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // Register writes and the serial cycle-timer shifter
    // -----------------------------------------------------------------
    always_comb begin
        nxt_ahdr1 = ahdr1_ff;
        nxt_ahdr2 = ahdr2_ff;
        nxt_ahdr3 = ahdr3_ff;
        nxt_iso_hdr = iso_hdr_ff;
        nxt_ctrl = ctrl_ff;
        nxt_alt = alt_ff;
        nxt_shift_cnt = shift_cnt_ff;
        nxt_ser_out = ser_out_ff;
        nxt_ser_act = ser_act_ff;
        wr_hit = 1'b1;
        unique case (waddr_ff)
            OFS_ASYNC_HDR_1: begin
                if (wr_fire) begin
                    nxt_ahdr1 = ahp_merge(ahdr1_ff, wdata_ff, wstrb_ff, MASK_FULL);
                end
            end
            OFS_ASYNC_HDR_2: begin
                if (wr_fire) begin
                    nxt_ahdr2 = ahp_merge(ahdr2_ff, wdata_ff, wstrb_ff, MASK_FULL);
                end
            end
            OFS_ASYNC_HDR_3: begin
                if (wr_fire) begin
                    nxt_ahdr3 = ahp_merge(ahdr3_ff, wdata_ff, wstrb_ff, MASK_FULL);
                end
            end
            OFS_ISO_TX_HDR: begin
                if (wr_fire) begin
                    // Length, tag, channel, speed and sync fields; the gap reads zero.
                    nxt_iso_hdr = ahp_merge(iso_hdr_ff, wdata_ff, wstrb_ff,
                                            MASK_ISO_TX_HDR);
                end
            end
            OFS_PKT_CTRL: begin
                if (wr_fire) begin
                    nxt_ctrl = ahp_merge(ctrl_ff, wdata_ff, wstrb_ff, MASK_PKT_CTRL);
                end
            end
            OFS_ALT_CTRL: begin
                if (wr_fire && (shift_cnt_ff == 6'h00)) begin
                    nxt_alt = ahp_merge(alt_ff, wdata_ff, wstrb_ff, MASK_FULL);
                end
            end
            default: wr_hit = 1'b0;
        endcase
        // The shifter owns the alternate register while a word is going out.
        // The active flag rises with the first bit and falls after the last one.
        if (ser_en && iso_cycle_start) begin
            nxt_alt = cycle_timer;
            nxt_shift_cnt = SHIFT_BITS;
            nxt_ser_act = 1'b0;
            nxt_ser_out = 1'b0;
        end else if (shift_cnt_ff != 6'h00) begin
            nxt_ser_out = alt_ff[31] && ser_en;
            nxt_alt = {alt_ff[30:0], 1'b0};
            nxt_shift_cnt = ser_en ? shift_cnt_ff - 6'h01 : 6'h00;
            nxt_ser_act = ser_en;
        end else begin
            nxt_ser_out = 1'b0;
            nxt_ser_act = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!srst_n) begin
            ahdr1_ff <= RST_ASYNC_HDR_1;
            ahdr2_ff <= RST_ASYNC_HDR_2;
            ahdr3_ff <= RST_ASYNC_HDR_3;
            iso_hdr_ff <= RST_ISO_TX_HDR;
            ctrl_ff <= RST_PKT_CTRL;
            alt_ff <= RST_ALT_CTRL;
            shift_cnt_ff <= '0;
            ser_out_ff <= 1'b0;
            ser_act_ff <= 1'b0;
        end else begin
            ahdr1_ff <= nxt_ahdr1;
            ahdr2_ff <= nxt_ahdr2;
            ahdr3_ff <= nxt_ahdr3;
            iso_hdr_ff <= nxt_iso_hdr;
            ctrl_ff <= nxt_ctrl;
            alt_ff <= nxt_alt;
            shift_cnt_ff <= nxt_shift_cnt;
            ser_out_ff <= nxt_ser_out;
            ser_act_ff <= nxt_ser_act;
        end
    end

    // -----------------------------------------------------------------
    // Test packet generator
    // -----------------------------------------------------------------
    ahp_gen_state_t state_ff, nxt_state;
    logic [15:0] remain_ff, nxt_remain;
    logic [31:0] count_ff, nxt_count;
    logic [31:0] hdr_ff, nxt_hdr;
    logic pend_ff, nxt_pend;
    logic [32:0] gen_data;
    logic gen_valid;
    logic gen_ready;
    logic [15:0] send_len;

    always_comb begin
        nxt_state = state_ff;
        nxt_remain = remain_ff;
        nxt_count = count_ff;
        nxt_hdr = hdr_ff;
        nxt_pend = pend_ff;
        gen_valid = 1'b0;
        gen_data = '0;
        // Transport-stream mode takes the cycle when both modes are on.
        send_len = ts_test_en ? TS_PKT_BYTES : iso_hdr_ff[LEN_LSB +: 16];
        // A cycle start that lands mid-packet is kept for the packet that follows.
        if (iso_cycle_start && (ts_test_en || iso_test_en)) begin
            nxt_pend = 1'b1;
        end
        unique case (state_ff)
            GEN_IDLE: begin
                if (pend_ff && (ts_test_en || iso_test_en)) begin
                    nxt_pend = iso_cycle_start;
                    nxt_hdr = {send_len, iso_hdr_ff[15:0] & MASK_ISO_TX_HDR[15:0]};
                    nxt_remain = ahp_quadlets(send_len);
                    nxt_state = GEN_HDR;
                end else if (!(ts_test_en || iso_test_en)) begin
                    nxt_pend = 1'b0;
                end
            end
            GEN_HDR: begin
                gen_valid = 1'b1;
                gen_data = {(remain_ff == 16'h0000), hdr_ff};
                if (gen_ready) begin
                    nxt_state = (remain_ff == 16'h0000) ? GEN_IDLE : GEN_DATA;
                end
            end
            GEN_DATA: begin
                gen_valid = 1'b1;
                gen_data = {(remain_ff == 16'h0001), count_ff};
                if (gen_ready) begin
                    nxt_count = count_ff + 32'h0000_0001;
                    nxt_remain = remain_ff - 16'h0001;
                    if (remain_ff == 16'h0001) begin
                        nxt_state = GEN_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!srst_n) begin
            state_ff <= GEN_IDLE;
            remain_ff <= '0;
            count_ff <= '0;
            hdr_ff <= '0;
            pend_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            remain_ff <= nxt_remain;
            count_ff <= nxt_count;
            hdr_ff <= nxt_hdr;
            pend_ff <= nxt_pend;
        end
    end

    ahp_skid_buf #(
        .W(33)
    ) u_buf (
        .aclk(aclk),
        .srst_n(srst_n),
        .in_data(gen_data),
        .in_valid(gen_valid),
        .in_ready(gen_ready),
        .out_data({pkt_last, pkt_data}),
        .out_valid(pkt_valid),
        .out_ready(pkt_ready)
    );

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign cyc_ser_out = ser_out_ff;
    assign cyc_ser_active = ser_act_ff;

endmodule // ahp_packetizer_cfg

// >>> logic/ahp_pkg.sv
// Constants, register map and types for the auto transmit header packetizer.
package ahp_pkg;

    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_ASYNC_HDR_1 = 12'h1B4;
    localparam logic [11:0] OFS_ASYNC_HDR_2 = 12'h1B8;
    localparam logic [11:0] OFS_ASYNC_HDR_3 = 12'h1BC;
    localparam logic [11:0] OFS_ISO_TX_HDR = 12'h1C0;
    localparam logic [11:0] OFS_PKT_CTRL = 12'h1C4;
    localparam logic [11:0] OFS_ALT_CTRL = 12'h1D8;

    localparam logic [31:0] RST_ASYNC_HDR_1 = 32'h3FC1_0000;
    localparam logic [31:0] RST_ASYNC_HDR_2 = 32'h0000_0000;
    localparam logic [31:0] RST_ASYNC_HDR_3 = 32'h0008_0000;
    localparam logic [31:0] RST_ISO_TX_HDR = 32'h0010_0010;
    localparam logic [31:0] RST_PKT_CTRL = 32'h8000_0000;
    localparam logic [31:0] RST_ALT_CTRL = 32'h0000_0000;
    localparam logic [31:0] MASK_FULL = 32'hFFFF_FFFF;
    localparam logic [31:0] MASK_ISO_TX_HDR = 32'hFFFF_FF3F;
    localparam logic [31:0] MASK_PKT_CTRL = 32'hB000_0000;

    // -----------------------------------------------------------------
    // Field positions (bit 00 of the map is the most significant bit)
    // -----------------------------------------------------------------
    localparam int LEN_LSB = 16;
    localparam int TAG_LSB = 14;
    localparam int CHAN_LSB = 8;
    localparam int SPEED_LSB = 4;
    localparam int SYNC_LSB = 0;
    localparam int CTL_SER_BIT = 31;
    localparam int CTL_TS_TEST_BIT = 29;
    localparam int CTL_ISO_TEST_BIT = 28;

    localparam logic [15:0] TS_PKT_BYTES = 16'h00BC;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [5:0] SHIFT_BITS = 6'h20;

    typedef enum logic [1:0] {
        GEN_IDLE,
        GEN_HDR,
        GEN_DATA
    } ahp_gen_state_t;

    // Applies byte strobes and the implemented-bit mask to a register write.
    function automatic logic [31:0] ahp_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res & mask;
    endfunction

    // Number of payload quadlets for a length in bytes, rounded up.
    function automatic logic [15:0] ahp_quadlets(input logic [15:0] len);
        logic [16:0] sum;
        sum = {1'b0, len} + 17'h0_0003;
        return {1'b0, sum[16:2]};
    endfunction

endpackage

// >>> logic/ahp_skid_buf.sv
// Two-entry valid/ready buffer whose output side comes straight from flip-flops.
`timescale 1ns/1ps
module ahp_skid_buf #(
    parameter int W = 33
) (
    input wire logic aclk,
    input wire logic srst_n,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    logic [W-1:0] out_data_ff, nxt_out_data;
    logic out_valid_ff, nxt_out_valid;
    logic [W-1:0] skid_data_ff, nxt_skid_data;
    logic skid_valid_ff, nxt_skid_valid;
    logic take;

    always_comb begin
        take = in_valid && !skid_valid_ff;
        nxt_out_data = out_data_ff;
        nxt_out_valid = out_valid_ff;
        nxt_skid_data = skid_data_ff;
        nxt_skid_valid = skid_valid_ff;
        if (out_ready || !out_valid_ff) begin
            if (skid_valid_ff) begin
                nxt_out_data = skid_data_ff;
                nxt_out_valid = 1'b1;
                nxt_skid_valid = 1'b0;
            end else begin
                nxt_out_data = in_data;
                nxt_out_valid = take;
            end
        end else if (take) begin
            nxt_skid_data = in_data;
            nxt_skid_valid = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!srst_n) begin
            out_data_ff <= '0;
            out_valid_ff <= 1'b0;
            skid_data_ff <= '0;
            skid_valid_ff <= 1'b0;
        end else begin
            out_data_ff <= nxt_out_data;
            out_valid_ff <= nxt_out_valid;
            skid_data_ff <= nxt_skid_data;
            skid_valid_ff <= nxt_skid_valid;
        end
    end

    assign in_ready = !skid_valid_ff;
    assign out_data = out_data_ff;
    assign out_valid = out_valid_ff;

endmodule // ahp_skid_buf
